// >>> dac_cfg_pkg.sv
// Package with command codes, field positions, reset values and register map.
package dac_cfg_pkg;

  localparam int          CMD_W            = 24;
  localparam int          CHAN_N           = 4;
  localparam logic [3:0]  OP_LATCH_CFG     = 4'h6;
  localparam logic [3:0]  OP_REFERENCE     = 4'h7;
  localparam int          OP_HI            = 23;
  localparam int          OP_LO            = 20;
  localparam int          ALL_SEL_POS      = 19;
  localparam int          REF_HOLD_POS     = 18;
  localparam int          REF_SEL_HI_POS   = 17;
  localparam int          REF_SEL_LO_POS   = 16;
  localparam int          LATCH_BIT_POS    = 16;
  localparam int          CHAN_SEL_LO      = 8;
  localparam int          PD_HI_POS        = 17;
  localparam int          PD_LO_POS        = 16;
  localparam logic [3:0]  LATCH_RESET      = 4'h0;
  localparam logic [1:0]  REF_SEL_RESET    = 2'h0;
  localparam logic        REF_HOLD_RESET   = 1'b0;
  localparam logic [7:0]  PD_RESET         = 8'h00;
  localparam logic [11:0] ZERO_CODE        = 12'h000;

  localparam int          CLK_HZ           = 25_000_000;
  localparam int          CAL_TIME_US      = 200;
  localparam int          CAL_CYCLES       = (CAL_TIME_US * (CLK_HZ / 1_000_000));

  localparam logic [11:0] ADDR_CMD         = 12'h000;
  localparam logic [11:0] ADDR_STATUS      = 12'h004;
  localparam logic [11:0] ADDR_POWER       = 12'h008;
  localparam logic [11:0] ADDR_CODE0       = 12'h010;

  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  typedef enum logic [1:0] {REF_EXTERNAL, REF_INT_2V5, REF_INT_2V048, REF_INT_4V096} ref_src_e;

endpackage : dac_cfg_pkg

// >>> dac_cmd_decode.sv
// Combinational decoder for the latch configuration and reference commands.
`timescale 1ns/1ps
module dac_cmd_decode
  import dac_cfg_pkg::*;
(
  input  wire logic [CMD_W-1:0]  cmdWord,
  output logic                   isLatchCfg,
  output logic                   isReference,
  output logic [CHAN_N-1:0]      chanMask,
  output logic                   latchValue,
  output logic [1:0]             refSelect,
  output logic                   refHold
);

  always_comb
  begin
    isLatchCfg  = (cmdWord[OP_HI:OP_LO] == OP_LATCH_CFG);
    isReference = (cmdWord[OP_HI:OP_LO] == OP_REFERENCE);
    if (cmdWord[ALL_SEL_POS])
    begin
      chanMask = {CHAN_N{1'b1}};
    end
    else
    begin
      chanMask = cmdWord[CHAN_SEL_LO +: CHAN_N];
    end
    latchValue = cmdWord[LATCH_BIT_POS];
    refSelect  = {cmdWord[REF_SEL_HI_POS], cmdWord[REF_SEL_LO_POS]};
    refHold    = cmdWord[REF_HOLD_POS];
  end

endmodule : dac_cmd_decode

// >>> dac_config_ref_command_decoder.sv
// Latch configuration and reference command decoder with an AXI4-Lite slave.
//
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module dac_config_ref_command_decoder
  import dac_cfg_pkg::*;
#(
  parameter int CAL_COUNT = CAL_CYCLES
)
(
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  wire logic [11:0]       s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [11:0]       s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [CHAN_N-1:0]      latchTransparent,
  output logic [1:0]             refSource,
  output logic                   refPowered,
  output logic                   standby,
  output logic                   calDone,
  output logic [4*12-1:0]        chanCode
);

  // ************************************************************
  // Reset synchroniser.
  // ************************************************************
  logic        rstMeta;
  logic        rstSync;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end
    else
    begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // ************************************************************
  // Write channel capture.
  // ************************************************************
  logic        awHeld;
  logic        wHeld;
  logic [11:0] awAddr;
  logic [31:0] wData;
  logic [3:0]  wStrb;
  logic        doWrite;

  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;
  assign doWrite       = awHeld && wHeld;

  always_ff @(posedge clk_sys or negedge rstSync)
  begin
    if (!rstSync)
    begin
      awHeld <= 1'b0;
      awAddr <= 12'h000;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      awHeld <= 1'b1;
      awAddr <= s_axi_awaddr;
    end
    else if (doWrite)
    begin
      awHeld <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync)
  begin
    if (!rstSync)
    begin
      wHeld <= 1'b0;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      wHeld <= 1'b1;
      wData <= s_axi_wdata;
      wStrb <= s_axi_wstrb;
    end
    else if (doWrite)
    begin
      wHeld <= 1'b0;
    end
  end

  function automatic logic addrKnown(input logic [11:0] addr);
    addrKnown = (addr == ADDR_CMD) || (addr == ADDR_STATUS) || (addr == ADDR_POWER)
                || (addr == ADDR_CODE0) || (addr == ADDR_CODE0 + 12'h004)
                || (addr == ADDR_CODE0 + 12'h008) || (addr == ADDR_CODE0 + 12'h00C);
  endfunction : addrKnown

  always_ff @(posedge clk_sys or negedge rstSync)
  begin
    if (!rstSync)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (doWrite)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= addrKnown(awAddr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ************************************************************
  // Command decode.
  // ************************************************************
  logic              cmdStrobe;
  logic [CMD_W-1:0]  cmdWord;
  logic              isLatchCfg;
  logic              isReference;
  logic [CHAN_N-1:0] chanMask;
  logic              latchValue;
  logic [1:0]        refSelect;
  logic              refHold;

  assign cmdStrobe = doWrite && (awAddr == ADDR_CMD) && (&wStrb[2:0]);
  assign cmdWord   = wData[CMD_W-1:0];

  dac_cmd_decode u_decode (
    .cmdWord     (cmdWord),
    .isLatchCfg  (isLatchCfg),
    .isReference (isReference),
    .chanMask    (chanMask),
    .latchValue  (latchValue),
    .refSelect   (refSelect),
    .refHold     (refHold)
  );

  // ************************************************************
  // Latch mode per channel.
  // ************************************************************
  always_ff @(posedge clk_sys or negedge rstSync)
  begin
    if (!rstSync)
    begin
      latchTransparent <= LATCH_RESET;
    end
    else if (cmdStrobe && isLatchCfg)
    begin
      for (int i = 0; i < CHAN_N; i++)
      begin
        if (chanMask[i])
        begin
          latchTransparent[i] <= latchValue;
        end
      end
    end
  end

  // ************************************************************
  // Global reference setting.
  // ************************************************************
  logic refHoldReg;

  always_ff @(posedge clk_sys or negedge rstSync)
  begin
    if (!rstSync)
    begin
      refSource  <= REF_SEL_RESET;
      refHoldReg <= REF_HOLD_RESET;
    end
    else if (cmdStrobe && isReference)
    begin
      refSource  <= refSelect;
      refHoldReg <= refHold;
    end
  end

  // ************************************************************
  // Channel power modes and standby.
  // ************************************************************
  logic [7:0] pdMode;

  always_ff @(posedge clk_sys or negedge rstSync)
  begin
    if (!rstSync)
    begin
      pdMode <= PD_RESET;
    end
    else if (doWrite && (awAddr == ADDR_POWER) && wStrb[0])
    begin
      pdMode <= wData[7:0];
    end
  end

  function automatic logic chanDown(input logic [7:0] modes, input int idx);
    chanDown = (modes[2*idx +: 2] != 2'b00);
  endfunction : chanDown

  logic       next_standby;
  logic       next_refPowered;

  always_comb
  begin
    next_standby = 1'b1;
    for (int i = 0; i < CHAN_N; i++)
    begin
      next_standby = next_standby && chanDown(pdMode, i);
    end
    next_refPowered = (refSource != REF_EXTERNAL) && (!next_standby || refHoldReg);
  end

  always_ff @(posedge clk_sys or negedge rstSync)
  begin
    if (!rstSync)
    begin
      standby    <= 1'b0;
      refPowered <= 1'b0;
    end
    else
    begin
      standby    <= next_standby;
      refPowered <= next_refPowered;
    end
  end

  // ************************************************************
  // Channel codes, zero-scale after power-up.
  // ************************************************************
  always_ff @(posedge clk_sys or negedge rstSync)
  begin
    if (!rstSync)
    begin
      chanCode <= {CHAN_N{ZERO_CODE}};
    end
    else
    begin
      for (int i = 0; i < CHAN_N; i++)
      begin
        if (doWrite && (awAddr == ADDR_CODE0 + 12'(4 * i)) && (&wStrb[1:0]))
        begin
          chanCode[12*i +: 12] <= wData[11:0];
        end
      end
    end
  end

  // ************************************************************
  // Calibration timer after reset.
  // ************************************************************
  logic [$clog2(CAL_COUNT+1)-1:0] calCount;

  always_ff @(posedge clk_sys or negedge rstSync)
  begin
    if (!rstSync)
    begin
      calCount <= '0;
      calDone  <= 1'b0;
    end
    else if (!calDone)
    begin
      calCount <= calCount + 1'b1;
      calDone  <= (calCount == ($bits(calCount))'(CAL_COUNT - 1));
    end
  end

  // ************************************************************
  // Read channel.
  // ************************************************************
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk_sys or negedge rstSync)
  begin
    if (!rstSync)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= addrKnown(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        ADDR_STATUS:
          s_axi_rdata <= {22'h0, calDone, refPowered, standby, refHoldReg, refSource, latchTransparent};
        ADDR_POWER:
          s_axi_rdata <= {24'h0, pdMode};
        ADDR_CODE0:
          s_axi_rdata <= {20'h0, chanCode[11:0]};
        ADDR_CODE0 + 12'h004:
          s_axi_rdata <= {20'h0, chanCode[23:12]};
        ADDR_CODE0 + 12'h008:
          s_axi_rdata <= {20'h0, chanCode[35:24]};
        ADDR_CODE0 + 12'h00C:
          s_axi_rdata <= {20'h0, chanCode[47:36]};
        default:
          s_axi_rdata <= 32'h0000_0000;
      endcase
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : dac_config_ref_command_decoder

// >>> dac_cfg_chk.sv
// Port checker for the latch configuration and reference command decoder.
`timescale 1ns/1ps
module dac_cfg_chk
  import dac_cfg_pkg::*;
#(
  parameter int CAL_COUNT = CAL_CYCLES
)
(
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [3:0]  latchTransparent,
  input wire logic [1:0]  refSource,
  input wire logic        refPowered,
  input wire logic        standby,
  input wire logic        calDone,
  input wire logic [47:0] chanCode
);
  int unsigned up;

  // Counts cycles since reset release, saturating past the calibration time.
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
      up <= 0;
    else if (up < CAL_COUNT + 8)
      up <= up + 1;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_reset_clear: assert property (disable iff (1'b0)
    !resetn |-> latchTransparent == 4'h0 && refSource == 2'h0 && chanCode == 48'h0 && !calDone)
    else $error("outputs not cleared in reset");
  a_ref_ext_off: assert property (refSource == 2'h0 |=> !refPowered)
    else $error("reference powered with external source");
  a_ref_active_on: assert property (refSource != 2'h0 ##1 !standby |-> refPowered)
    else $error("internal reference off outside standby");
  a_cfg_on_write: assert property ($changed(latchTransparent) || $changed(refSource) |-> $rose(s_axi_bvalid))
    else $error("settings changed without a write response");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_busy_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_cal_time: assert property ((up < CAL_COUNT |-> !calDone) and (up > CAL_COUNT + 4 |-> calDone))
    else $error("calibration done flag mistimed");
endmodule : dac_cfg_chk

// >>> axi_host.sv
// Register bus host model issuing command, power and status transfers.
`timescale 1ns/1ps
module axi_host
(
  input  wire logic        clk_sys,
  output logic [11:0]      s_axi_awaddr,
  output logic [2:0]       s_axi_awprot,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [11:0]      s_axi_araddr,
  output logic [2:0]       s_axi_arprot,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  bit slow;

  initial
  begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, s_axi_awprot, s_axi_arprot} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
  end

  // Slow mode raises the response ready only after the response is seen.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    bit pa, pw, hb, rb;
    @(posedge clk_sys);
    pa = 1'b1;
    pw = 1'b1;
    hb = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= !slow;
    while (!hb)
    begin
      @(negedge clk_sys);
      pa = pa && !s_axi_awready;
      pw = pw && !s_axi_wready;
      hb = s_axi_bvalid && s_axi_bready;
      rb = s_axi_bvalid;
      @(posedge clk_sys);
      s_axi_awvalid <= pa;
      s_axi_wvalid <= pw;
      s_axi_bready <= (s_axi_bready || rb) && !hb;
    end
  endtask : wr

  task automatic rd(input logic [11:0] a);
    bit pa, hr, rv;
    @(posedge clk_sys);
    pa = 1'b1;
    hr = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= !slow;
    while (!hr)
    begin
      @(negedge clk_sys);
      pa = pa && !s_axi_arready;
      hr = s_axi_rvalid && s_axi_rready;
      rv = s_axi_rvalid;
      @(posedge clk_sys);
      s_axi_arvalid <= pa;
      s_axi_rready <= (s_axi_rready || rv) && !hr;
    end
  endtask : rd
endmodule : axi_host

// >>> tb.sv
// Self-checking testbench for the command decoder.
`timescale 1ns/1ps
module tb
  import dac_cfg_pkg::*;
;
  localparam int CAL_COUNT = 20;
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b1;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed = 32'h4EB5;
  logic [3:0]  s_axi_wstrb, latchTransparent, lat;
  logic [1:0]  s_axi_bresp, s_axi_rresp, refSource, rsel;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, refPowered, standby, calDone;
  logic        hold, calx;
  logic [7:0]  pm;
  logic [47:0] chanCode;
  logic [33:0] expq[$];
  logic [33:0] got;
  int          fails = 0;
  int          tests_run = 0;
  int          cyc = 0;

  dac_config_ref_command_decoder #(.CAL_COUNT(CAL_COUNT)) dut_u (.*);
  axi_host host_u (.*);

  initial
  begin
    forever #20 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic [31:0] status();
    logic sb;
    sb = (pm[1:0] != 2'h0) && (pm[3:2] != 2'h0) && (pm[5:4] != 2'h0) && (pm[7:6] != 2'h0);
    return {22'h0, calx, (rsel != 2'h0) && (!sb || hold), sb, hold, rsel, lat};
  endfunction : status

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize

  task automatic check(input logic [33:0] e);
    tests_run = tests_run + 1;
    if (got !== e)
    begin
      fails = fails + 1;
      $display("[ERR] %0t got %h expected %h", $time, got, e);
    end
  endtask : check

  // Each response handshake is compared with the oldest noted expectation.
  always @(negedge clk_sys)
  begin
    if (resetn && ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)))
    begin
      got = s_axi_bvalid ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata};
      check(expq.pop_front());
    end
  end

  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      fails = fails + 1;
      summarize();
    end
  end

  task automatic bus_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    expq.push_back({r, 32'h0});
    host_u.wr(a, d, 4'hF);
  endtask : bus_wr

  task automatic bus_rd(input logic [11:0] a, input logic [31:0] d);
    expq.push_back({RESP_OKAY, d});
    host_u.rd(a);
  endtask : bus_rd

  task automatic do_reset();
    resetn <= 1'b0;
    {lat, rsel, hold, calx, pm} = '0;
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask : do_reset

  initial
  begin
    logic [31:0] r;
    logic [23:0] cmd;
    logic [3:0]  sel;
    do_reset();
    bus_rd(ADDR_STATUS, status());
    for (int i = 0; i < 4; i++)
      bus_rd(ADDR_CODE0 + 12'(4 * i), 32'h0);
    repeat (CAL_COUNT) @(posedge clk_sys);
    calx = 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      r = xs();
      host_u.slow = r[31];
      cmd = {(i % 4 == 3) ? 4'h9 : OP_LATCH_CFG, r[19:0]};
      sel = r[19] ? 4'hF : r[11:8];
      if (cmd[23:20] == OP_LATCH_CFG)
        lat = r[16] ? (lat | sel) : (lat & ~sel);
      bus_wr(ADDR_CMD, {8'h0, cmd}, RESP_OKAY);
      bus_rd(ADDR_STATUS, status());
    end
    for (int k = 0; k < 3; k++)
    begin
      pm = (k == 0) ? 8'h00 : (k == 1) ? 8'hE4 : 8'h9B;
      bus_wr(ADDR_POWER, {24'h0, pm}, RESP_OKAY);
      for (int j = 0; j < 8; j++)
      begin
        r = xs();
        host_u.slow = r[30];
        {hold, rsel} = 3'(j);
        bus_wr(ADDR_CMD, {8'h0, OP_REFERENCE, r[19], 3'(j), r[15:0]}, RESP_OKAY);
        bus_rd(ADDR_STATUS, status());
      end
    end
    bus_wr(12'h100, 32'h0070_0000, RESP_SLVERR);
    bus_rd(ADDR_STATUS, status());
    for (int i = 0; i < 4; i++)
    begin
      r = xs();
      bus_wr(ADDR_CODE0 + 12'(4 * i), r, RESP_OKAY);
      bus_rd(ADDR_CODE0 + 12'(4 * i), {20'h0, r[11:0]});
    end
    do_reset();
    bus_rd(ADDR_STATUS, status());
    for (int i = 0; i < 4; i++)
      bus_rd(ADDR_CODE0 + 12'(4 * i), 32'h0);
    summarize();
  end
endmodule : tb

bind dac_config_ref_command_decoder dac_cfg_chk #(.CAL_COUNT(CAL_COUNT)) chk_u (.*);
